// file: hdl/ecg_serial_pkg.sv
// constants shared by the ecg frame serial port design
// assumes a 10 MHz system clock; all times become cycle counts here
package ecg_serial_pkg;
  // system clock
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned CLK_NS       = 100;
  // frame rates selectable in the frame control port
  localparam int unsigned RATE_2K_HZ   = 2_000;
  localparam int unsigned RATE_16K_HZ  = 16_000;
  localparam int unsigned RATE_128K_HZ = 128_000;
  localparam int unsigned TICK_2K      = CLK_HZ / RATE_2K_HZ;
  localparam int unsigned TICK_16K     = CLK_HZ / RATE_16K_HZ;
  localparam int unsigned TICK_128K    = CLK_HZ / RATE_128K_HZ;
  localparam logic [1:0]  RATE_SEL_2K   = 2'h0;
  localparam logic [1:0]  RATE_SEL_16K  = 2'h1;
  localparam logic [1:0]  RATE_SEL_128K = 2'h2;
  // frame control port fields
  localparam int unsigned FRM_RATE_LSB  = 0;
  localparam int unsigned FRM_SKIP_LSB  = 2;
  localparam int unsigned FRM_SPW_BIT   = 4;
  // acquisition control port: high performance mode bit
  localparam int unsigned ACQ_HP_BIT    = 3;
  // word and frame geometry
  localparam int unsigned WORD_BITS      = 16;
  localparam int unsigned MAIN_WORDS     = 5;
  localparam int unsigned SEC_WORDS      = 7;
  localparam int unsigned HOST_WORD_BITS = 32;
  localparam int unsigned MAIN_BITS      = MAIN_WORDS * WORD_BITS;
  localparam int unsigned SEC_BITS       = SEC_WORDS * WORD_BITS;
  // secondary port clock: 2.5 times an 8.192 MHz crystal
  localparam int unsigned XTAL_HZ        = 8_192_000;
  localparam int unsigned SEC_CLK_HZ     = XTAL_HZ * 5 / 2;
  localparam int unsigned SEC_HALF_RAW   = CLK_HZ / (2 * SEC_CLK_HZ);
  localparam int unsigned SEC_HALF_CYC   = (SEC_HALF_RAW > 0) ?
                                           SEC_HALF_RAW : 1;
  // select high time between frames, least times round up
  localparam int unsigned GAP_FRAME_NS   = 2173;
  localparam int unsigned GAP_WORD_NS    = 2026;
  localparam int unsigned GAP_FRAME_CYC  = (GAP_FRAME_NS + CLK_NS - 1)
                                           / CLK_NS;
  localparam int unsigned GAP_WORD_CYC   = (GAP_WORD_NS + CLK_NS - 1)
                                           / CLK_NS;
  // clock held high between words: one secondary clock period
  localparam int unsigned WGAP_CYC       = 2 * SEC_HALF_CYC;
  // reset pin least low time
  localparam int unsigned RST_LOW_NS     = 20;
  localparam int unsigned RST_LOW_RAW    = (RST_LOW_NS + CLK_NS - 1)
                                           / CLK_NS;
  localparam int unsigned RST_LOW_CYC    = (RST_LOW_RAW > 0) ?
                                           RST_LOW_RAW : 1;
  // secondary port states
  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_WGAP, S_FGAP} sec_state_e;
endpackage : ecg_serial_pkg

// file: hdl/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk_sys_in
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             reset_in,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;  // first stage, read only by second

  // two stages, reset to the idle level of each pin
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      meta_r   <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_r   <= pin_in;
      sync_out <= meta_r;
    end
  end
endmodule : pin_sync

// file: hdl/ecg_frame_serial_ports.sv
// ecg frame serial ports: main slave port and secondary master port
// assumes host pins are asynchronous; frame words come from same clock
// Functional notes
// - frames at 2, 16 or 128 kHz, plus skip
// - main output changes after host clock falling edge
// - main input sampled on host clock rising edge
// - select optional; tied low still works
// - main output enabled only while select asserted
// - main port uses clock idle high, phase one
// - reset pin acts on its falling edge
// - secondary port runs only in high performance mode
// - secondary port frames only at 128 kHz
// - secondary clock is system clock halved (5 MHz), not 2.5 times crystal
// - secondary data changes on its clock rising edge
// - whole-frame select held low across frame
// - per-word select; clock high between words
// - order: header, three channels, two zeros, crc
// - select high 2173 or 2026 ns between frames
`timescale 1ns/1ps
module ecg_frame_serial_ports #(
  parameter int unsigned TICK_2K_CYC = ecg_serial_pkg::TICK_2K
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  // device reset pin, edge triggered
  input  wire logic        dev_reset_n_in,
  // control bits
  input  wire logic [7:0]  frame_control_reg_in,
  input  wire logic [7:0]  acq_control_reg_in,
  // frame words from the acquisition path
  input  wire logic [15:0] frame_header_in,
  input  wire logic [15:0] ecg_ch1_in,
  input  wire logic [15:0] ecg_ch2_in,
  input  wire logic [15:0] ecg_ch3_in,
  input  wire logic [15:0] frame_crc_in,
  // main slave port pins
  input  wire logic        host_sclk_in,
  input  wire logic        host_cs_n_in,
  input  wire logic        host_sdi_in,
  output logic             host_sdo_out,
  output logic             host_sdo_oe_n_out,
  output logic             data_ready_n_out,
  // words received from the host
  output logic [31:0]      host_word_out,
  output logic             host_word_valid_out,
  // secondary master port pins
  output logic             sec_port_clock_out,
  output logic             sec_port_select_n_out,
  output logic             sec_port_data_out
);
  localparam int unsigned MB = ecg_serial_pkg::MAIN_BITS;
  localparam int unsigned SB = ecg_serial_pkg::SEC_BITS;

  // whole state of the block
  typedef struct packed {
    logic                         sclk_d;   // previous host clock
    logic                         rstp_d;   // previous reset pin
    logic [1:0]                   rate;     // latched frame rate
    logic [1:0]                   skip;     // latched skip exponent
    logic                         spw;      // latched select per word
    logic                         hp;       // latched high perf mode
    logic [12:0]                  tick;     // frame period counter
    logic [2:0]                   skip_cnt; // frames skipped so far
    logic [MB-1:0]                mbuf;     // newest main frame
    logic                         data_ready_n_n;   // new frame waiting
    logic [MB-1:0]                tx;       // main output shifter
    logic [6:0]                   tx_cnt;   // bits left in tx
    logic                         sdo;      // main output bit
    logic                         sdo_oe_n; // main output enable
    logic [31:0]                  rx;       // main input shifter
    logic [4:0]                   rx_cnt;   // bits received
    logic [31:0]                  rx_word;  // last host word
    logic                         rx_valid; // host word pulse
    ecg_serial_pkg::sec_state_e   sst;      // secondary port state
    logic [SB-1:0]                sbuf;     // secondary shifter
    logic [3:0]                   bit_cnt;  // rises in current word
    logic [2:0]                   word_cnt; // word in frame
    logic [4:0]                   gap_cnt;  // select high counter
    logic [1:0]                   half;     // half period counter
    logic                         sclk;     // secondary clock
    logic                         scs_n;    // secondary select
    logic                         sdo2;     // secondary data
  } state_s;

  state_s s_r;    // registered state
  state_s s_nxt;  // next state

  logic [3:0] pins_s;  // synchronised host pins and reset pin
  logic       sclk_s;  // host clock after sync
  logic       cs_n_s;  // host select after sync
  logic       sdi_s;   // host data after sync
  logic       rstp_s;  // reset pin after sync

  // host pins and reset pin through two flip-flops
  pin_sync #(
    .WIDTH (4),
    .INIT  (4'hb)
  ) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .pin_in     ({dev_reset_n_in, host_sdi_in, host_cs_n_in,
                  host_sclk_in}),
    .sync_out   (pins_s)
  );

  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign sdi_s  = pins_s[2];
  assign rstp_s = pins_s[3];

  logic        m_rise;    // host clock rising edge seen
  logic        m_fall;    // host clock falling edge seen
  logic        soft_rst;  // reset pin falling edge
  logic        boundary;  // end of a frame period
  logic        emit;      // frame released this period
  logic [12:0] tick_lim;  // period length minus one for current rate
  logic [2:0]  skip_lim;  // frames per emitted frame minus one
  logic [MB-1:0] m_src;   // main shifter source

  // edge detection and frame timing
  always_comb
  begin
    m_rise   = sclk_s & ~s_r.sclk_d;
    m_fall   = ~sclk_s & s_r.sclk_d;
    soft_rst = s_r.rstp_d & ~rstp_s;
    unique case (s_r.rate)
      ecg_serial_pkg::RATE_SEL_128K:
        tick_lim = 13'(ecg_serial_pkg::TICK_128K - 1);
      ecg_serial_pkg::RATE_SEL_16K:
        tick_lim = 13'(ecg_serial_pkg::TICK_16K - 1);
      default:
        tick_lim = 13'(TICK_2K_CYC - 1);
    endcase
    skip_lim = 3'((1 << s_r.skip) - 1);
    boundary = (s_r.tick == tick_lim);
    emit     = boundary && (s_r.skip_cnt == 3'h0);
    m_src    = (s_r.tx_cnt == 7'h0) ? s_r.mbuf : s_r.tx;
  end

  // next state of the whole block
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.sclk_d   = sclk_s;
    s_nxt.rstp_d   = rstp_s;
    s_nxt.rx_valid = 1'b0;
    // frame period counter and skip
    if (boundary)
    begin
      s_nxt.tick     = 13'h0;
      s_nxt.skip_cnt = (s_r.skip_cnt >= skip_lim) ? 3'h0
                       : s_r.skip_cnt + 3'h1;
      // modes change only between frames
      s_nxt.rate = frame_control_reg_in[
                   ecg_serial_pkg::FRM_RATE_LSB +: 2];
      s_nxt.skip = frame_control_reg_in[
                   ecg_serial_pkg::FRM_SKIP_LSB +: 2];
      if (s_r.sst == ecg_serial_pkg::S_IDLE)
      begin
        s_nxt.spw = frame_control_reg_in[ecg_serial_pkg::FRM_SPW_BIT];
        s_nxt.hp  = acq_control_reg_in[ecg_serial_pkg::ACQ_HP_BIT];
      end
    end
    else
      s_nxt.tick = s_r.tick + 13'h1;
    // main slave port: select gates everything
    s_nxt.sdo_oe_n = cs_n_s;
    if (cs_n_s)
    begin
      // select high: restart word framing, optional select
      s_nxt.tx_cnt = 7'h0;
      s_nxt.rx_cnt = 5'h0;
    end
    else
    begin
      // capture on rising host clock, idle high phase one
      if (m_rise)
      begin
        s_nxt.rx     = {s_r.rx[30:0], sdi_s};
        s_nxt.rx_cnt = s_r.rx_cnt + 5'h1;
        if (s_r.rx_cnt == 5'h1f)
        begin
          s_nxt.rx_word  = {s_r.rx[30:0], sdi_s};
          s_nxt.rx_valid = 1'b1;
        end
      end
      // launch after falling host clock, reload when empty
      if (m_fall)
      begin
        s_nxt.sdo = m_src[MB-1];
        s_nxt.tx  = {m_src[MB-2:0], 1'b0};
        s_nxt.tx_cnt = (s_r.tx_cnt == 7'h0) ? 7'(MB - 1)
                       : s_r.tx_cnt - 7'h1;
        if (s_r.tx_cnt == 7'h0)
          s_nxt.data_ready_n_n = 1'b1;
      end
    end
    // new frame into the main buffer; set wins over the read clear
    if (emit)
    begin
      s_nxt.mbuf   = {frame_header_in, ecg_ch1_in, ecg_ch2_in,
                      ecg_ch3_in, frame_crc_in};
      s_nxt.data_ready_n_n = 1'b0;
    end
    // secondary master port
    unique case (s_r.sst)
      ecg_serial_pkg::S_IDLE:
      begin
        s_nxt.sclk  = 1'b1;
        s_nxt.scs_n = 1'b1;
        s_nxt.sdo2  = 1'b0;
        // only high performance mode at 128 kHz
        if (emit && s_r.hp && s_r.rate == ecg_serial_pkg::RATE_SEL_128K)
        begin
          s_nxt.sbuf = {frame_header_in, ecg_ch1_in, ecg_ch2_in,
                        ecg_ch3_in, 16'h0000, 16'h0000, frame_crc_in};
          s_nxt.sdo2     = frame_header_in[15];
          s_nxt.scs_n    = 1'b0;
          s_nxt.bit_cnt  = 4'h0;
          s_nxt.word_cnt = 3'h0;
          s_nxt.half     = 2'(ecg_serial_pkg::SEC_HALF_CYC - 1);
          s_nxt.sst      = ecg_serial_pkg::S_SHIFT;
        end
      end
      ecg_serial_pkg::S_SHIFT:
      begin
        // clock divided from the system clock
        if (s_r.half != 2'h0)
          s_nxt.half = s_r.half - 2'h1;
        else
        begin
          s_nxt.half = 2'(ecg_serial_pkg::SEC_HALF_CYC - 1);
          if (s_r.sclk)
            s_nxt.sclk = 1'b0;
          else
          begin
            s_nxt.sclk = 1'b1;
            if (s_r.bit_cnt != 4'hf)
            begin
              // next bit on the rising edge
              s_nxt.sbuf    = {s_r.sbuf[SB-2:0], 1'b0};
              s_nxt.sdo2    = s_r.sbuf[SB-2];
              s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
            end
            else if (s_r.word_cnt == 3'(ecg_serial_pkg::SEC_WORDS - 1))
            begin
              // frame done: select high for the frame gap
              s_nxt.scs_n   = 1'b1;
              s_nxt.sdo2    = 1'b0;
              s_nxt.gap_cnt = s_r.spw ?
                              5'(ecg_serial_pkg::GAP_WORD_CYC - 1) :
                              5'(ecg_serial_pkg::GAP_FRAME_CYC - 1);
              s_nxt.sst     = ecg_serial_pkg::S_FGAP;
            end
            else if (s_r.spw)
            begin
              // per-word select, clock held high between words
              s_nxt.scs_n   = 1'b1;
              s_nxt.gap_cnt = 5'(ecg_serial_pkg::WGAP_CYC - 1);
              s_nxt.sst     = ecg_serial_pkg::S_WGAP;
            end
            else
            begin
              // select stays low into the next word
              s_nxt.sbuf     = {s_r.sbuf[SB-2:0], 1'b0};
              s_nxt.sdo2     = s_r.sbuf[SB-2];
              s_nxt.bit_cnt  = 4'h0;
              s_nxt.word_cnt = s_r.word_cnt + 3'h1;
            end
          end
        end
      end
      ecg_serial_pkg::S_WGAP:
      begin
        // clock high, select high, then next word
        if (s_r.gap_cnt != 5'h0)
          s_nxt.gap_cnt = s_r.gap_cnt - 5'h1;
        else
        begin
          s_nxt.scs_n    = 1'b0;
          s_nxt.sbuf     = {s_r.sbuf[SB-2:0], 1'b0};
          s_nxt.sdo2     = s_r.sbuf[SB-2];
          s_nxt.bit_cnt  = 4'h0;
          s_nxt.word_cnt = s_r.word_cnt + 3'h1;
          s_nxt.sst      = ecg_serial_pkg::S_SHIFT;
        end
      end
      ecg_serial_pkg::S_FGAP:
      begin
        // least select high time before another frame
        if (s_r.gap_cnt != 5'h0)
          s_nxt.gap_cnt = s_r.gap_cnt - 5'h1;
        else
          s_nxt.sst = ecg_serial_pkg::S_IDLE;
      end
    endcase
    // reset pin edge returns the block to its reset state
    if (soft_rst)
    begin
      s_nxt        = '0;
      s_nxt.rstp_d = rstp_s;
      s_nxt.sclk_d = sclk_s;
      s_nxt.data_ready_n_n = 1'b1;
      s_nxt.sdo_oe_n = 1'b1;
      s_nxt.sclk   = 1'b1;
      s_nxt.scs_n  = 1'b1;
    end
  end

  // one register for the whole state
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s_r          <= '0;
      s_r.sclk_d   <= 1'b1;
      s_r.rstp_d   <= 1'b1;
      s_r.data_ready_n_n   <= 1'b1;
      s_r.sdo_oe_n <= 1'b1;
      s_r.sclk     <= 1'b1;
      s_r.scs_n    <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from the state register
  assign host_sdo_out          = s_r.sdo;
  assign host_sdo_oe_n_out     = s_r.sdo_oe_n;
  assign data_ready_n_out      = s_r.data_ready_n_n;
  assign host_word_out         = s_r.rx_word;
  assign host_word_valid_out   = s_r.rx_valid;
  assign sec_port_clock_out    = s_r.sclk;
  assign sec_port_select_n_out = s_r.scs_n;
  assign sec_port_data_out     = s_r.sdo2;

  // helper: cycles the secondary select has stayed high
  logic [5:0] scs_hi_cnt;
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      scs_hi_cnt <= 6'h3f;
    else if (!s_r.scs_n)
      scs_hi_cnt <= 6'h0;
    else if (scs_hi_cnt != 6'h3f)
      scs_hi_cnt <= scs_hi_cnt + 6'h1;
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  sdo_enable_a: assert property (cs_n_s |=> host_sdo_oe_n_out)
    else $error("main output enabled without select");
  sdo_launch_a: assert property ($changed(host_sdo_out)
      |-> $past(m_fall) || $past(soft_rst))
    else $error("main output moved without host clock fall");
  rx_capture_a: assert property (host_word_valid_out
      |-> $past(m_rise) && !$past(cs_n_s))
    else $error("host word completed without rising clock");
  sec_start_a: assert property ($fell(sec_port_select_n_out)
      && $past(s_r.sst == ecg_serial_pkg::S_IDLE)
      |-> $past(s_r.hp)
      && $past(s_r.rate) == ecg_serial_pkg::RATE_SEL_128K)
    else $error("secondary frame outside 128 kHz high perf");
  sec_data_rise_a: assert property ($changed(sec_port_data_out)
      |-> $rose(sec_port_clock_out) || $changed(sec_port_select_n_out))
    else $error("secondary data moved off rising clock");
  sec_whole_cs_a: assert property (!s_r.spw
      && s_r.sst == ecg_serial_pkg::S_SHIFT |-> !sec_port_select_n_out)
    else $error("select released inside whole frame");
  sec_word_gap_a: assert property (s_r.sst == ecg_serial_pkg::S_WGAP
      |-> sec_port_clock_out && sec_port_select_n_out)
    else $error("clock or select low between words");
  sec_gap_len_a: assert property ($fell(sec_port_select_n_out)
      && $past(s_r.sst == ecg_serial_pkg::S_IDLE)
      |-> $past(scs_hi_cnt) >= (s_r.spw ?
          6'(ecg_serial_pkg::GAP_WORD_CYC - 1) :
          6'(ecg_serial_pkg::GAP_FRAME_CYC - 1)))
    else $error("select high time between frames too short");
  rate_latch_a: assert property ($changed(s_r.rate)
      |-> $past(boundary) || $past(soft_rst))
    else $error("frame rate changed inside a frame");
  data_ready_n_emit_a: assert property ($fell(data_ready_n_out) |-> $past(emit))
    else $error("ready flagged without a new frame");

  sec_frame_c: cover property ($rose(sec_port_select_n_out)
      && $past(s_r.word_cnt) == 3'h6);
  sec_word_c: cover property (s_r.sst == ecg_serial_pkg::S_WGAP);
  host_word_c: cover property (host_word_valid_out);
  main_read_c: cover property ($rose(data_ready_n_out) && !cs_n_s);
endmodule : ecg_frame_serial_ports

// file: sim/pace_link_model.sv
// far-side model: pace logic receiving the secondary port frames
// assumes pins are registered outputs of the block on clk_sys_in
`timescale 1ns/1ps
module pace_link_model (
  // clock
  input  wire logic         clk_sys_in,
  // secondary port pins
  input  wire logic         sec_clk_in,
  input  wire logic         sel_n_in,
  input  wire logic         data_in,
  // captured frame, gap and period
  output logic [111:0]      frame_out = '0,
  output logic [15:0]       frames_out = '0,
  output logic [15:0]       gap_out = '0,
  output logic [15:0]       period_out = '0,
  output logic [15:0]       fault_out = '0
);
  logic [6:0]   bits_r = '0;  // bits taken in this frame
  logic [111:0] shift_r = '0; // frame being assembled
  logic [15:0]  high_r = '0;  // select high run, clk cycles
  logic [15:0]  cyc_r = '0;   // free cycle count
  logic [15:0]  start_r = '0; // cycle of last frame start
  logic         clk_q_r = 1'b1;
  logic         sel_q_r = 1'b1;
  logic         dat_q_r = 1'b0;
  // take data on falling clock while selected
  always @(negedge sec_clk_in)
    if (!sel_n_in)
    begin
      shift_r = {shift_r[110:0], data_in};
      bits_r  = bits_r + 7'h1;
      if (bits_r == 7'h70)
      begin
        frame_out  = shift_r;
        frames_out = frames_out + 16'h1;
        bits_r     = '0;
      end
    end
  // pin timing watch on the system clock
  always @(posedge clk_sys_in)
  begin
    cyc_r = cyc_r + 16'h1;
    if (sel_n_in && !sec_clk_in)
      fault_out = fault_out + 16'h1; // clock low outside select
    if (data_in != dat_q_r && !(sec_clk_in && !clk_q_r) &&
        sel_n_in == sel_q_r)
      fault_out = fault_out + 16'h1; // data moves off a clock rise
    if (!sel_n_in && sel_q_r && bits_r == 7'h0)
    begin
      gap_out    = high_r;
      period_out = cyc_r - start_r;
      start_r    = cyc_r;
    end
    high_r  = sel_n_in ? high_r + 16'h1 : 16'h0;
    clk_q_r = sec_clk_in;
    sel_q_r = sel_n_in;
    dat_q_r = data_in;
  end
endmodule : pace_link_model

// file: sim/ecg_frame_serial_ports_test.sv
// self-checking bench for the ecg frame serial ports
// assumes the design package and pace_link_model are compiled first
`timescale 1ns/1ps
module ecg_frame_serial_ports_test;
  logic        clk = 1'b0, rst = 1'b1, dev_rst_n = 1'b1;
  logic [7:0]  frm = 8'h00, acq = 8'h00;
  logic [15:0] hdr = '0, c1 = '0, c2 = '0, c3 = '0, crc = '0;
  logic        host_sclk = 1'b1, host_cs_n = 1'b0, host_sdi = 1'b0;
  logic        sdo, oe_n, rdy_n, wvalid, sclk2, sel_n, sdat;
  logic [31:0] word, got_word = '0;
  logic [111:0] pl_frame;
  logic [15:0] pl_frames, pl_gap, pl_per, pl_fault;
  logic [79:0] dout;
  logic [31:0] din;
  int          n_fail = 0, check_count = 0;
  ecg_frame_serial_ports #(.TICK_2K_CYC(200)) ecg_frame_serial_ports_i (
    .clk_sys_in(clk), .reset_in(rst), .dev_reset_n_in(dev_rst_n),
    .frame_control_reg_in(frm), .acq_control_reg_in(acq),
    .frame_header_in(hdr), .ecg_ch1_in(c1), .ecg_ch2_in(c2),
    .ecg_ch3_in(c3), .frame_crc_in(crc), .host_sclk_in(host_sclk),
    .host_cs_n_in(host_cs_n), .host_sdi_in(host_sdi),
    .host_sdo_out(sdo), .host_sdo_oe_n_out(oe_n),
    .data_ready_n_out(rdy_n), .host_word_out(word),
    .host_word_valid_out(wvalid), .sec_port_clock_out(sclk2),
    .sec_port_select_n_out(sel_n), .sec_port_data_out(sdat));
  pace_link_model pace_link_model_i (
    .clk_sys_in(clk), .sec_clk_in(sclk2), .sel_n_in(sel_n),
    .data_in(sdat), .frame_out(pl_frame), .frames_out(pl_frames),
    .gap_out(pl_gap), .period_out(pl_per), .fault_out(pl_fault));
  // 10 MHz system clock
  always #50 clk = ~clk;
  // keep the last word received from the host
  always @(posedge clk)
    if (wvalid === 1'b1)
      got_word <= word;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // expected main port frame: header, three channels, crc
  function automatic logic [79:0] main_frame();
    return {hdr, c1, c2, c3, crc};
  endfunction : main_frame
  // expected secondary frame: two zero words before the crc
  function automatic logic [111:0] sec_frame();
    return {hdr, c1, c2, c3, 16'h0000, 16'h0000, crc};
  endfunction : sec_frame
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // fresh random frame words
  task automatic new_words;
    hdr <= 16'($urandom);
    c1  <= 16'($urandom);
    c2  <= 16'($urandom);
    c3  <= 16'($urandom);
    crc <= 16'($urandom);
    cyc(1);
  endtask : new_words
  // one 80-clock host transfer, link clock idle high, 800 ns period
  task automatic host_xfer;
    dout = '0;
    for (int i = 0; i < 80; i++)
    begin
      host_sclk <= 1'b0;
      host_sdi  <= din[31 - (i % 32)];
      cyc(4);
      host_sclk <= 1'b1;
      dout = {dout[78:0], sdo};
      cyc(4);
    end
    check(dout, main_frame());
    check(got_word, din);
  endtask : host_xfer
  // wait for n more secondary frames, bounded
  task automatic wait_frames(input int n);
    int t;
    t = pl_frames + n;
    for (int k = 0; k < 4000 && pl_frames < t; k++)
      cyc(1);
    check(pl_frames >= t, 1'b1);
  endtask : wait_frames
  // watchdog
  initial
  begin
    cyc(40000);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'hb6f8f619));
    cyc(10);
    rst <= 1'b0;
    new_words();
    din = $urandom;
    cyc(500);
    host_xfer();
    // framed transfer with select
    host_cs_n <= 1'b1;
    new_words();
    din = $urandom;
    cyc(500);
    check(oe_n, 1'b1);
    host_cs_n <= 1'b0;
    cyc(4);
    check(oe_n, 1'b0);
    host_xfer();
    host_cs_n <= 1'b1;
    // device reset pin pulse
    dev_rst_n <= 1'b0;
    cyc(4);
    check({word, rdy_n, sel_n, sclk2}, {32'h0, 3'h7});
    dev_rst_n <= 1'b1;
    // secondary frames, whole-frame then per-word select
    acq <= 8'h08;
    for (int s = 0; s < 2; s++)
    begin
      frm <= {3'h0, s[0], 4'h2};
      new_words();
      wait_frames(3);
      check(pl_frame, sec_frame());
      check(pl_gap * ecg_serial_pkg::CLK_NS >= (s ?
            ecg_serial_pkg::GAP_WORD_NS : ecg_serial_pkg::GAP_FRAME_NS),
            1'b1);
      check(pl_per % ecg_serial_pkg::TICK_128K, 0);
      check(pl_fault, 16'h0);
    end
    // skip mode: one frame of eight
    frm <= 8'h0e;
    wait_frames(3);
    check(pl_per % (8 * ecg_serial_pkg::TICK_128K), 0);
    // no frames without high performance or below 128 kHz
    for (int m = 0; m < 2; m++)
    begin
      acq <= m ? 8'h08 : 8'h00;
      frm <= m ? 8'h01 : 8'h02;
      cyc(600);
      din = pl_frames;
      cyc(1000);
      check(pl_frames, din[15:0]);
    end
    give_verdict();
  end
endmodule : ecg_frame_serial_ports_test
